// ==== src/mds_pkg.sv ====
// Shared constants and types for the multiply/divide sequencer.
package mds_pkg;
  localparam int WORD_W = 18;
  localparam int ACC_W = 2 * WORD_W;
  localparam int OPC_W = 6;
  localparam int CNT_W = 5;
  localparam int ADDR_W = 16;
  localparam int SIGN_BIT = WORD_W - 1;

  localparam logic [OPC_W-1:0] OPC_MUL_A = 6'h14;
  localparam logic [OPC_W-1:0] OPC_MUL_B = 6'h15;
  localparam logic [OPC_W-1:0] OPC_DIV_DIRECT = 6'h16;
  localparam logic [OPC_W-1:0] OPC_DIV_INDEXED = 6'h17;

  // Step counts are octal 23 and octal 22.
  localparam logic [CNT_W-1:0] MUL_STEPS = 5'h13;
  localparam logic [CNT_W-1:0] DIV_STEPS = 5'h12;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;

  // Master-clock phases within one step, .1 to .4.
  localparam logic [1:0] PH_1 = 2'h0;
  localparam logic [1:0] PH_2 = 2'h1;
  localparam logic [1:0] PH_3 = 2'h2;
  localparam logic [1:0] PH_4 = 2'h3;

  localparam logic [WORD_W-1:0] WORD_ZERO = 18'h00000;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 16'h0000;

  typedef enum logic [2:0] {
    MDS_IDLE  = 3'b000,
    MDS_FETCH = 3'b001,
    MDS_PREP  = 3'b010,
    MDS_ITER  = 3'b011,
    MDS_FIX   = 3'b100
  } mds_state_t;
endpackage

// ==== src/mds_arith_if.sv ====
// Connection from the sequencer to its adder and step counter.
`timescale 1ns/100ps
interface mds_arith_if;
  import mds_pkg::*;
  logic [WORD_W-1:0] add_a;
  logic [WORD_W-1:0] add_b;
  logic [WORD_W-1:0] add_sum;
  logic add_carry;
  logic cnt_load;
  logic [CNT_W-1:0] cnt_init;
  logic cnt_dec;
  logic cnt_xfer;
  logic [CNT_W-1:0] cnt_value;
  logic cnt_zero;
  modport seq (output add_a, add_b, cnt_load, cnt_init, cnt_dec, cnt_xfer,
               input add_sum, add_carry, cnt_value, cnt_zero);
  modport adder (input add_a, add_b, output add_sum, add_carry);
  modport counter (input cnt_load, cnt_init, cnt_dec, cnt_xfer,
                   output cnt_value, cnt_zero);
endinterface

// ==== src/mds_adder.sv ====
// One's-complement adder with end-around carry.
`timescale 1ns/100ps
module mds_adder (
  mds_arith_if.adder ar
);
  import mds_pkg::*;
  logic [WORD_W:0] raw;
  logic [WORD_W:0] wrapped;

  // The carry out of the top is fed back into the bottom.
  assign raw = {1'b0, ar.add_a} + {1'b0, ar.add_b};
  assign wrapped = {1'b0, raw[WORD_W-1:0]} + {{WORD_W{1'b0}}, raw[WORD_W]};
  assign ar.add_sum = wrapped[WORD_W-1:0];
  assign ar.add_carry = raw[WORD_W];
endmodule

// ==== src/mds_step_counter.sv ====
// Step counter and its decrement adder, moved in separate phases.
`timescale 1ns/100ps
module mds_step_counter (
  input wire logic clock,
  input wire logic rst_b,
  mds_arith_if.counter ar
);
  import mds_pkg::*;
  logic [CNT_W-1:0] step_counter_r;
  logic [CNT_W-1:0] step_counter_adder_r;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      step_counter_r <= CNT_ZERO;
    end else if (ar.cnt_load) begin
      step_counter_r <= ar.cnt_init;
    end else if (ar.cnt_xfer) begin
      step_counter_r <= step_counter_adder_r;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      step_counter_adder_r <= CNT_ZERO;
    end else if (ar.cnt_load) begin
      step_counter_adder_r <= CNT_ZERO;
    end else if (ar.cnt_dec) begin
      step_counter_adder_r <= step_counter_r - CNT_ONE;
    end
  end

  assign ar.cnt_value = step_counter_r;
  assign ar.cnt_zero = (step_counter_r == CNT_ZERO);
endmodule

// ==== src/mds_sequencer.sv ====
// Multiply and divide sequencer for the one's-complement accumulator pair.
`timescale 1ns/100ps
module mds_sequencer #(
  parameter int ADDRESS_WIDTH = mds_pkg::ADDR_W
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [mds_pkg::OPC_W-1:0] opcode,
  input wire logic [ADDRESS_WIDTH-1:0] address_field,
  input wire logic [ADDRESS_WIDTH-1:0] index_value,
  input wire logic operand_valid,
  input wire logic [mds_pkg::WORD_W-1:0] operand_data,
  input wire logic acc_load,
  input wire logic [mds_pkg::WORD_W-1:0] upper_accumulator_in,
  input wire logic [mds_pkg::WORD_W-1:0] lower_accumulator_in,
  output logic [mds_pkg::WORD_W-1:0] upper_accumulator,
  output logic [mds_pkg::WORD_W-1:0] lower_accumulator,
  output logic operand_request,
  output logic [ADDRESS_WIDTH-1:0] operand_address,
  output logic hold_1,
  output logic hold_2,
  output logic iteration_enable_a,
  output logic iteration_enable_b,
  output logic busy,
  output logic done,
  output logic divide_overflow
);
  import mds_pkg::*;

  // Complementing a one's-complement word negates it, so one helper serves every sign fix.
  function automatic logic [WORD_W-1:0] cond_compl(input logic [WORD_W-1:0] v,
                                                  input logic c);
    cond_compl = c ? ~v : v;
  endfunction

  function automatic logic is_neg(input logic [WORD_W-1:0] v);
    is_neg = v[SIGN_BIT];
  endfunction

  mds_arith_if ar ();

  mds_adder u_adder (
    .ar(ar.adder)
  );

  mds_step_counter u_counter (
    .clock(clock),
    .rst_b(rst_b),
    .ar(ar.counter)
  );

  mds_state_t state_r;
  mds_state_t state_nxt;
  logic [1:0] phase_r;
  logic is_div_r;
  logic [WORD_W-1:0] upper_r;
  logic [WORD_W-1:0] lower_r;
  logic [WORD_W-1:0] operand_r;
  logic [WORD_W-1:0] x_r;
  logic [WORD_W-1:0] w_r;
  logic store_r;
  logic y_neg_r;
  logic a_neg_r;
  logic hold_1_r;
  logic hold_2_r;
  logic enable_a_r;
  logic enable_b_r;
  logic request_r;
  logic [ADDRESS_WIDTH-1:0] address_r;
  logic busy_r;
  logic done_r;
  logic overflow_r;
  logic op_mul;
  logic op_div;
  logic iterating;
  logic step_end;

  assign op_mul = (opcode == OPC_MUL_A) || (opcode == OPC_MUL_B);
  assign op_div = (opcode == OPC_DIV_DIRECT) || (opcode == OPC_DIV_INDEXED);
  assign iterating = enable_a_r && enable_b_r && (state_r == MDS_ITER);
  assign step_end = iterating && (phase_r == PH_4);

  // The adder sees the shifted partial value and the held operand.
  assign ar.add_a = x_r;
  assign ar.add_b = operand_r;
  // The count is loaded in the single preparation cycle, before the first step.
  assign ar.cnt_load = (state_r == MDS_PREP);
  assign ar.cnt_init = is_div_r ? DIV_STEPS : MUL_STEPS;
  assign ar.cnt_dec = iterating && (phase_r == PH_1);
  assign ar.cnt_xfer = iterating && (phase_r == PH_2);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      MDS_IDLE: begin
        if (start && (op_mul || op_div)) begin
          state_nxt = MDS_FETCH;
        end
      end
      MDS_FETCH: begin
        if (operand_valid) begin
          state_nxt = MDS_PREP;
        end
      end
      MDS_PREP: begin
        state_nxt = MDS_ITER;
      end
      MDS_ITER: begin
        // The count was moved into the counter at phase 2 of this step.
        if (step_end && ar.cnt_zero) begin
          state_nxt = MDS_FIX;
        end
      end
      MDS_FIX: begin
        state_nxt = MDS_IDLE;
      end
      default: begin
        state_nxt = MDS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= MDS_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Each step takes four clocks; outside the iterations the phase rests at phase 1.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      phase_r <= PH_1;
    end else if (iterating) begin
      phase_r <= phase_r + 2'h1;
    end else begin
      phase_r <= PH_1;
    end
  end

  // The kind of operation is latched so a later opcode change cannot alter a running step.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      is_div_r <= 1'b0;
    end else if (state_r == MDS_IDLE && start) begin
      is_div_r <= op_div;
    end
  end

  // Operand fetch; the indexed divide adds the index to the address field.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      request_r <= 1'b0;
      address_r <= ADDR_ZERO;
    end else if (state_r == MDS_IDLE && start && (op_mul || op_div)) begin
      request_r <= 1'b1;
      if (opcode == OPC_DIV_INDEXED) begin
        address_r <= address_field + index_value;
      end else begin
        address_r <= address_field;
      end
    end else if (state_r == MDS_FETCH && operand_valid) begin
      request_r <= 1'b0;
    end
  end

  // Original signs of operand and accumulator, kept for the final correction.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      y_neg_r <= 1'b0;
      a_neg_r <= 1'b0;
    end else if (state_r == MDS_FETCH && operand_valid) begin
      y_neg_r <= is_neg(operand_data);
      a_neg_r <= is_div_r ? is_neg(upper_r) : is_neg(lower_r);
    end
  end

  // Multiply keeps a positive multiplicand, divide a negative divisor.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      operand_r <= WORD_ZERO;
    end else if (state_r == MDS_FETCH && operand_valid) begin
      if (is_div_r) begin
        operand_r <= cond_compl(operand_data, !is_neg(operand_data));
      end else begin
        operand_r <= cond_compl(operand_data, is_neg(operand_data));
      end
    end
  end

  // Shift into the staging registers and sample the multiplier bit.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      x_r <= WORD_ZERO;
      w_r <= WORD_ZERO;
      store_r <= 1'b0;
    end else if (iterating && phase_r == PH_1) begin
      if (is_div_r) begin
        x_r <= {upper_r[WORD_W-2:0], lower_r[WORD_W-1]};
        w_r <= {lower_r[WORD_W-2:0], 1'b0};
        store_r <= 1'b0;
      end else begin
        x_r <= {1'b0, upper_r[WORD_W-1:1]};
        w_r <= {upper_r[0], lower_r[WORD_W-1:1]};
        store_r <= lower_r[0];
      end
    end
  end

  // The shifted-out upper bit is lost; this is only flagged, never avoided.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      overflow_r <= 1'b0;
    end else if (state_r == MDS_IDLE && start) begin
      overflow_r <= 1'b0;
    end else if (iterating && is_div_r && phase_r == PH_1 && upper_r[WORD_W-1]) begin
      overflow_r <= 1'b1;
    end
  end

  // Accumulator pair: load, sign preparation, step results and final fixup.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      upper_r <= WORD_ZERO;
      lower_r <= WORD_ZERO;
    end else if (acc_load && state_r == MDS_IDLE) begin
      upper_r <= upper_accumulator_in;
      lower_r <= lower_accumulator_in;
    end else if (state_r == MDS_PREP) begin
      if (is_div_r) begin
        // A negative double-length dividend is complemented as a whole.
        upper_r <= cond_compl(upper_r, a_neg_r);
        lower_r <= cond_compl(lower_r, a_neg_r);
      end else begin
        // The partial product starts from zero whatever was loaded before.
        upper_r <= WORD_ZERO;
        lower_r <= cond_compl(lower_r, a_neg_r);
      end
    end else if (iterating && phase_r == PH_3) begin
      if (is_div_r) begin
        // Carry out of the trial sum means no end-around borrow.
        upper_r <= ar.add_carry ? ar.add_sum : x_r;
        lower_r <= {w_r[WORD_W-1:1], ar.add_carry};
      end else begin
        upper_r <= store_r ? ar.add_sum : x_r;
        lower_r <= w_r;
      end
    end else if (state_r == MDS_FIX) begin
      if (is_div_r) begin
        // The remainder keeps the dividend's sign; unlike signs make the quotient negative.
        upper_r <= cond_compl(upper_r, a_neg_r);
        lower_r <= cond_compl(lower_r, a_neg_r ^ y_neg_r);
      end else begin
        upper_r <= cond_compl(upper_r, a_neg_r ^ y_neg_r);
        lower_r <= cond_compl(lower_r, a_neg_r ^ y_neg_r);
      end
    end
  end

  // Enables open the iterations and close once the count has run out.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      enable_a_r <= 1'b0;
      enable_b_r <= 1'b0;
    end else if (state_r == MDS_PREP) begin
      enable_a_r <= 1'b1;
      enable_b_r <= 1'b1;
    end else if (step_end && ar.cnt_zero) begin
      enable_a_r <= 1'b0;
      enable_b_r <= 1'b0;
    end
  end

  // Hold the operand-read sequence until the result is final.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      hold_1_r <= 1'b0;
      hold_2_r <= 1'b0;
    end else if (state_r == MDS_FETCH && operand_valid) begin
      hold_1_r <= 1'b1;
      hold_2_r <= 1'b1;
    end else if (state_r == MDS_FIX) begin
      hold_1_r <= 1'b0;
      hold_2_r <= 1'b0;
    end
  end

  // Busy follows the next state, so it stands from the cycle after an accepted start.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= (state_nxt != MDS_IDLE);
    end
  end

  // Done is a one-cycle pulse; the corrected result stands on the accumulators with it.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      done_r <= 1'b0;
    end else begin
      done_r <= (state_r == MDS_FIX);
    end
  end

  assign upper_accumulator = upper_r;
  assign lower_accumulator = lower_r;
  assign operand_request = request_r;
  assign operand_address = address_r;
  assign hold_1 = hold_1_r;
  assign hold_2 = hold_2_r;
  assign iteration_enable_a = enable_a_r;
  assign iteration_enable_b = enable_b_r;
  assign busy = busy_r;
  assign done = done_r;
  assign divide_overflow = overflow_r;
endmodule

// ==== verif/mds_sequencer_sva.sv ====
// Port checker for the multiply/divide sequencer.
`timescale 1ns/100ps
module mds_sequencer_sva #(
  parameter int ADDRESS_WIDTH = mds_pkg::ADDR_W
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [mds_pkg::OPC_W-1:0] opcode,
  input wire logic [ADDRESS_WIDTH-1:0] address_field,
  input wire logic [ADDRESS_WIDTH-1:0] index_value,
  input wire logic operand_valid,
  input wire logic acc_load,
  input wire logic [mds_pkg::WORD_W-1:0] upper_accumulator_in,
  input wire logic [mds_pkg::WORD_W-1:0] upper_accumulator,
  input wire logic operand_request,
  input wire logic [ADDRESS_WIDTH-1:0] operand_address,
  input wire logic hold_1,
  input wire logic hold_2,
  input wire logic iteration_enable_a,
  input wire logic iteration_enable_b,
  input wire logic busy,
  input wire logic done,
  input wire logic divide_overflow
);
  import mds_pkg::*;
  logic take;
  logic is_mul_r;
  logic [ADDRESS_WIDTH-1:0] addr_r;
  assign take = start && !busy && (opcode inside {OPC_MUL_A, OPC_MUL_B, OPC_DIV_DIRECT,
    OPC_DIV_INDEXED});
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      is_mul_r <= 1'b0;
      addr_r <= '0;
    end else if (take) begin
      is_mul_r <= opcode inside {OPC_MUL_A, OPC_MUL_B};
      addr_r <= address_field + ((opcode == OPC_DIV_INDEXED) ? index_value : '0);
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  AST_START_REQ: assert property (take |=> operand_request && busy)
    else $error("accepted start did not raise the operand request");
  AST_ADDR: assert property (take |=> operand_address == addr_r)
    else $error("operand address wrong");
  AST_HOLD_SET: assert property (operand_request && operand_valid |=> hold_1 && hold_2)
    else $error("holds not set at operand accept");
  AST_HOLD_KEEP: assert property (hold_1 |-> hold_2 && busy && !done)
    else $error("hold pair inconsistent");
  AST_EN_PAIR: assert property (iteration_enable_a |-> iteration_enable_b && hold_1)
    else $error("iteration enables not paired");
  AST_EN_RISE: assert property ($rose(hold_1) |=> iteration_enable_a)
    else $error("iterations not enabled after operand accept");
  AST_MUL_LEN: assert property ($rose(hold_1) && is_mul_r |-> ##78 done)
    else $error("multiply did not take nineteen steps");
  AST_DIV_LEN: assert property ($rose(hold_1) && !is_mul_r |-> ##74 done)
    else $error("divide did not take eighteen steps");
  AST_DONE_END: assert property (done |-> !hold_1 && !iteration_enable_a ##1 !done)
    else $error("done not a clean single pulse");
  AST_LOAD_IDLE: assert property (acc_load && !busy && !take |=>
    upper_accumulator == $past(upper_accumulator_in))
    else $error("idle accumulator load failed");
  cover property ($rose(hold_1) && is_mul_r);
  cover property ($rose(hold_1) && !is_mul_r);
  cover property ($rose(divide_overflow));
endmodule
bind mds_sequencer mds_sequencer_sva #(.ADDRESS_WIDTH(ADDRESS_WIDTH)) i_mds_sequencer_sva (.*);

// ==== verif/mds_mem_model.sv ====
// Operand memory that answers the sequencer's operand requests after a set lag.
`timescale 1ns/100ps
module mds_mem_model (
  input wire logic clock,
  input wire logic operand_request,
  input wire logic [mds_pkg::WORD_W-1:0] word,
  input wire logic [3:0] lag,
  output logic operand_valid,
  output logic [mds_pkg::WORD_W-1:0] operand_data
);
  logic [3:0] wait_cnt;
  initial begin
    operand_valid = 1'b0;
    operand_data = 18'h00000;
    wait_cnt = 4'h0;
  end
  // Outside the answer cycle the data lines toggle so a late sample cannot pass.
  always @(negedge clock) begin
    if (operand_request && !operand_valid && wait_cnt == lag) begin
      operand_valid <= 1'b1;
      operand_data <= word;
      wait_cnt <= 4'h0;
    end else begin
      operand_valid <= 1'b0;
      operand_data <= ~operand_data;
      wait_cnt <= operand_request ? wait_cnt + 4'h1 : 4'h0;
    end
  end
endmodule

// ==== verif/tb_top.sv ====
// Self-checking bench for the multiply/divide sequencer.
`timescale 1ns/100ps
module tb_top;
  import mds_pkg::*;
  logic clock, rst_b, start, acc_load, operand_valid, operand_request;
  logic hold_1, hold_2, en_a, en_b, busy, done, ovf;
  logic [OPC_W-1:0] opcode;
  logic [ADDR_W-1:0] addr, idx, operand_address;
  logic [WORD_W-1:0] upper_in, lower_in, upper_acc, lower_acc, operand_data, word;
  logic [3:0] lag;
  int n_fail, compares;
  mds_sequencer i_mds_sequencer (.clock, .rst_b, .start, .opcode, .address_field(addr),
    .index_value(idx), .operand_valid, .operand_data, .acc_load,
    .upper_accumulator_in(upper_in), .lower_accumulator_in(lower_in),
    .upper_accumulator(upper_acc), .lower_accumulator(lower_acc), .operand_request,
    .operand_address, .hold_1, .hold_2, .iteration_enable_a(en_a),
    .iteration_enable_b(en_b), .busy, .done, .divide_overflow(ovf));
  mds_mem_model i_mds_mem_model (.clock, .operand_request, .word, .lag, .operand_valid,
    .operand_data);
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [36:0] exp, input logic [36:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  function automatic logic [17:0] oc_add(input logic [17:0] a, input logic [17:0] b);
    logic [18:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[17:0] + {17'h00000, s[18]};
  endfunction
  // Models the shift-and-add loop as run, including its extra nineteenth shift.
  function automatic logic [36:0] mul_ref(input logic [17:0] y, input logic [17:0] al);
    logic [17:0] d, u, l, x;
    logic s;
    d = y[17] ? ~y : y;
    l = al[17] ? ~al : al;
    u = 18'h00000;
    repeat (19) begin
      s = l[0];
      x = {1'b0, u[17:1]};
      l = {u[0], l[17:1]};
      u = s ? oc_add(x, d) : x;
    end
    return {1'b0, (y[17] ^ al[17]) ? ~{u, l} : {u, l}};
  endfunction
  function automatic logic [36:0] div_ref(input logic [17:0] y, input logic [17:0] au,
    input logic [17:0] al);
    logic [17:0] d, u, l;
    logic [18:0] r;
    logic ov;
    ov = 1'b0;
    d = y[17] ? y : ~y;
    {u, l} = au[17] ? ~{au, al} : {au, al};
    repeat (18) begin
      ov = ov | u[17];
      {u, l} = {u[16:0], l, 1'b0};
      r = {1'b0, u} + {1'b0, d};
      if (r[18]) begin
        u = oc_add(u, d);
        l[0] = 1'b1;
      end
    end
    if (y[17] ^ au[17]) l = ~l;
    if (au[17]) u = ~u;
    return {ov, u, l};
  endfunction
  // One whole operation; with poke set a second start and a load are tried mid-run.
  task automatic run_op(input logic [5:0] opc, input logic [17:0] au, input logic [17:0] al,
    input logic [17:0] y, input logic [3:0] dly, input logic poke);
    logic [36:0] e;
    logic is_mul;
    int n;
    is_mul = opc < OPC_DIV_DIRECT;
    e = is_mul ? mul_ref(y, al) : div_ref(y, au, al);
    @(negedge clock);
    acc_load = 1'b1;
    upper_in = au;
    lower_in = al;
    word = y;
    lag = dly;
    @(negedge clock);
    acc_load = 1'b0;
    start = 1'b1;
    opcode = opc;
    @(negedge clock);
    start = 1'b0;
    chk("address", {21'h000000, (opc == OPC_DIV_INDEXED) ? addr + idx : addr},
      {21'h000000, operand_address});
    n = 0;
    while (hold_1 !== 1'b1 && n < 40) begin
      @(negedge clock);
      n++;
    end
    if (poke) begin
      start = 1'b1;
      opcode = OPC_DIV_DIRECT;
      acc_load = 1'b1;
      upper_in = ~au;
    end
    n = 0;
    while (done !== 1'b1 && n < 200) begin
      @(negedge clock);
      n++;
      start = 1'b0;
      acc_load = 1'b0;
    end
    chk("steps", is_mul ? 37'h0004e : 37'h0004a, 37'(n));
    chk("result", e, {ovf, upper_acc, lower_acc});
  endtask
  task automatic t_multiply;
    for (int i = 0; i < 4; i++) begin
      run_op(i[0] ? OPC_MUL_B : OPC_MUL_A, i[1] ? 18'h2aaaa : 18'h00000,
        i[0] ? ~18'h00007 : 18'h00007, i[1] ? ~18'h00005 : 18'h00005, 4'(i),
        1'b0);
    end
  endtask
  task automatic t_divide;
    for (int i = 0; i < 4; i++) begin
      run_op(i[0] ? OPC_DIV_INDEXED : OPC_DIV_DIRECT, i[1] ? 18'h3ffff : 18'h00000,
        i[1] ? ~18'h00064 : 18'h00064, i[0] ? ~18'h00007 : 18'h00007, 4'(3 - i),
        1'b0);
    end
  endtask
  task automatic t_overflow;
    run_op(OPC_DIV_DIRECT, 18'h10000, 18'h00000, 18'h00001, 4'h1, 1'b0);
  endtask
  task automatic t_refused;
    run_op(OPC_MUL_B, 18'h00000, 18'h00013, 18'h00009, 4'h2, 1'b1);
    @(negedge clock);
    start = 1'b1;
    opcode = 6'h18;
    @(negedge clock);
    start = 1'b0;
    chk("ignored start", 37'h0, {35'h0, busy, operand_request});
  endtask
  initial begin
    rst_b = 1'b0;
    start = 1'b0;
    acc_load = 1'b0;
    opcode = 6'h00;
    addr = 16'h0123;
    idx = 16'hfff0;
    upper_in = 18'h00000;
    lower_in = 18'h00000;
    word = 18'h00000;
    lag = 4'h0;
    n_fail = 0;
    compares = 0;
    repeat (20) @(negedge clock);
    rst_b = 1'b1;
    chk("reset", 37'h0, {ovf, upper_acc, lower_acc});
    t_multiply;
    t_divide;
    t_overflow;
    t_refused;
    tally_and_finish;
  end
  initial begin
    #(50 * 4000);
    n_fail++;
    $display("unexpected timeout: expected finish, seen hang");
    tally_and_finish;
  end
endmodule
